// ==== core/wdg_status_pkg.sv ====
// package of register offsets, reset values, field positions and timing constants
// assumes a register access port decoded by the serial slave outside this block
package wdg_status_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_WDG_CTRL    = 8'h0b;  // bus_watchdog_ctrl
    localparam logic [7:0] ADDR_TEST_STATUS = 8'h0c;  // led_test_status
    localparam logic [7:0] ADDR_DEV_STATUS  = 8'h0d;  // device_status

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] WDG_CTRL_RST    = 8'hff;   // monitor on, longest window
    localparam logic [7:0] TEST_STATUS_RST = 8'h00;   // no test, no errors
    localparam logic [7:0] DEV_STATUS_RST  = 8'h00;   // nothing pending

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int WDG_EN_BIT      = 0;               // monitor enable
    localparam int WDG_WIN_LSB     = 1;               // window field low bit
    localparam int WDG_WIN_W       = 7;               // window field width
    localparam int TEST_BUSY_BIT   = 6;               // test in progress
    localparam int TEST_SHORT_LSB  = 3;               // short results a..c
    localparam int TEST_OPEN_LSB   = 0;               // open results a..c
    localparam int DEV_PLAY_BIT    = 6;               // animation playing
    localparam int DEV_INT_LSB     = 4;               // interrupt cause low bit
    localparam int DEV_FRAME_LSB   = 0;               // frame index low bit

    // interrupt cause encodings
    localparam logic [1:0] INT_NONE = 2'h0;           // nothing
    localparam logic [1:0] INT_POR  = 2'h1;           // power-on reset
    localparam logic [1:0] INT_BUS  = 2'h2;           // bus monitor timeout

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;               // mclk period
    localparam int WIN_UNIT_NS   = 256000;            // one window unit, 256 us
    localparam int WIN_UNIT_CYC  = WIN_UNIT_NS / CLK_PERIOD_NS;  // 2560 cycles

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic       busy;                             // test running
        logic [2:0] shorted;                          // short found in c,b,a
        logic [2:0] opened;                           // open found in c,b,a
    } led_test_t;

    typedef struct packed {
        logic       playing;                          // animation playing
        logic [3:0] frame;                            // frame shown, 0..5
    } anim_state_t;

endpackage : wdg_status_pkg

// ==== core/bus_stuck_timer.sv ====
// deadlock timer for the serial slave: counts while the data line is held low
// assumes sda and scl samples already synchronous to mclk
`timescale 1ns/1ns
`default_nettype none

module bus_stuck_timer
    import wdg_status_pkg::*;
#(
    parameter int UNIT_CYCLES = WIN_UNIT_CYC,         // cycles per window unit
    parameter int WIN_W       = WDG_WIN_W             // window field width
) (
    input  wire logic             mclk,               // system clock
    input  wire logic             srst,               // sync reset
    input  wire logic             enable,             // monitor on
    input  wire logic [WIN_W-1:0] window_sel,         // n, window is n+1 units
    input  wire logic             sda_in,             // data line level
    input  wire logic             scl_in,             // clock line level
    output logic                  timeout             // one-cycle pulse
);

    localparam int CW = $clog2(UNIT_CYCLES);          // cycle-within-unit counter width

    // ************************************************************
    // state
    // ************************************************************
    logic             sda_prev_ff, nxt_sda_prev;      // last data sample
    logic             scl_prev_ff, nxt_scl_prev;      // last clock sample
    logic [CW-1:0]    cyc_ff, nxt_cyc;                // cycles within unit
    logic [WIN_W-1:0] unit_ff, nxt_unit;              // units elapsed
    logic             tout_ff, nxt_tout;              // timeout pulse
    logic             activity;                       // any line edge
    logic             stuck;                          // line held low, no edge

    // next-state computation
    always_comb begin
        activity     = (sda_in != sda_prev_ff) || (scl_in != scl_prev_ff);
        stuck        = enable && !sda_in && !activity;
        nxt_sda_prev = sda_in;
        nxt_scl_prev = scl_in;
        nxt_cyc      = cyc_ff;
        nxt_unit     = unit_ff;
        nxt_tout     = 1'b0;
        if (!stuck) begin
            // any activity or release restarts the window
            nxt_cyc  = '0;
            nxt_unit = '0;
        end else if (cyc_ff == CW'(UNIT_CYCLES - 1)) begin
            // one 256 us unit has passed
            nxt_cyc = '0;
            if (unit_ff >= window_sel) begin          // a window shortened mid-count ends now
                nxt_unit = '0;
                nxt_tout = 1'b1;
            end else begin
                nxt_unit = unit_ff + 1'b1;
            end
        end else begin
            nxt_cyc = cyc_ff + 1'b1;
        end
    end

    // registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            sda_prev_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            cyc_ff      <= '0;
            unit_ff     <= '0;
            tout_ff     <= 1'b0;
        end else begin
            sda_prev_ff <= nxt_sda_prev;
            scl_prev_ff <= nxt_scl_prev;
            cyc_ff      <= nxt_cyc;
            unit_ff     <= nxt_unit;
            tout_ff     <= nxt_tout;
        end
    end

    assign timeout = tout_ff;

    // ************************************************************
    // checks
    // ************************************************************
    chk_stuck_cause: assert property (@(posedge mclk) disable iff (srst)
        timeout |-> $past(enable) && !$past(sda_in))
        else $error("timeout without a held-low data line");
    chk_edge_restart: assert property (@(posedge mclk) disable iff (srst)
        activity |=> cyc_ff == '0 && unit_ff == '0 && !timeout)
        else $error("bus activity did not restart the timer");

endmodule : bus_stuck_timer

`default_nettype wire

// ==== core/bus_watchdog_and_status_regs.sv ====
// status and supervision register bank of the led matrix driver
// assumes the serial slave decodes register reads and writes into one-cycle strobes,
// and that test and animation logic elsewhere supply their live state
`timescale 1ns/1ns
`default_nettype none

// Function
// - reset serial slave after stuck-low window
// - window is (n+1) units of 256 us
// - monitoring register reads all ones after reset
// - test status read only, zero after reset
// - test status bit 6 shows test running
// - bits 3..5 flag shorts in a, b, c
// - bits 0..2 flag opens in a, b, c
// - interrupt field encodes none, por, bus, both
// - status read clears interrupt bits 5:4
// - power-on cause set after every start-up
// - status bit 6 shows animation playing
// - status bits 3:0 show displayed frame
module bus_watchdog_and_status_regs
    import wdg_status_pkg::*;
#(
    parameter int UNIT_CYCLES = WIN_UNIT_CYC          // cycles per window unit
) (
    input  wire logic        mclk,                    // system clock, 10 MHz
    input  wire logic        srst,                    // sync reset, active high
    input  wire logic [7:0]  reg_addr,                // register address
    input  wire logic        reg_wr,                  // write strobe
    input  wire logic [7:0]  reg_wdata,               // write data
    input  wire logic        reg_rd,                  // read strobe
    output logic      [7:0]  reg_rdata,               // read data, registered
    input  wire logic        sda_in,                  // serial data line level
    input  wire logic        scl_in,                  // serial clock line level
    output logic             slave_reset,             // pulse resets serial slave
    input  wire led_test_t   test_in,                 // live self-test state
    input  wire anim_state_t anim_in                  // live animation state
);

    // ************************************************************
    // decode
    // ************************************************************
    logic wr_wdg;                                     // write monitoring register
    logic rd_dev;                                     // read device status

    // strobes qualified by address
    always_comb begin
        wr_wdg = reg_wr && (reg_addr == ADDR_WDG_CTRL);
        rd_dev = reg_rd && (reg_addr == ADDR_DEV_STATUS);
    end

    // ************************************************************
    // monitoring register
    // ************************************************************
    logic [7:0] wdg_ctrl_ff, nxt_wdg_ctrl;            // enable and window

    // software writes the whole byte; no other source touches it
    always_comb begin
        nxt_wdg_ctrl = wdg_ctrl_ff;
        if (wr_wdg) begin
            nxt_wdg_ctrl = reg_wdata;
        end
    end

    // holds its longest window and monitor on after reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            wdg_ctrl_ff <= WDG_CTRL_RST;
        end else begin
            wdg_ctrl_ff <= nxt_wdg_ctrl;
        end
    end

    // ************************************************************
    // deadlock timer
    // ************************************************************
    logic bus_timeout;                                // one-cycle pulse

    bus_stuck_timer #(
        .UNIT_CYCLES (UNIT_CYCLES),
        .WIN_W       (WDG_WIN_W)
    ) u_timer (
        .mclk       (mclk),
        .srst       (srst),
        .enable     (wdg_ctrl_ff[WDG_EN_BIT]),
        .window_sel (wdg_ctrl_ff[WDG_WIN_LSB +: WDG_WIN_W]),
        .sda_in     (sda_in),
        .scl_in     (scl_in),
        .timeout    (bus_timeout)
    );

    // the slave interface is reset by the timer pulse itself
    assign slave_reset = bus_timeout;

    // ************************************************************
    // live status samples
    // ************************************************************
    logic [7:0] test_status_ff, nxt_test_status;      // self-test image
    logic       play_ff, nxt_play;                    // animation playing
    logic [3:0] frame_ff, nxt_frame;                  // frame shown

    // sample live state; bit 7 is unused and reads zero
    always_comb begin
        nxt_test_status                          = 8'h00;
        nxt_test_status[TEST_BUSY_BIT]           = test_in.busy;
        nxt_test_status[TEST_SHORT_LSB +: 3]     = test_in.shorted;
        nxt_test_status[TEST_OPEN_LSB +: 3]      = test_in.opened;
        nxt_play                                 = anim_in.playing;
        nxt_frame                                = anim_in.frame;
    end

    // zero after reset; writes never reach these
    always_ff @(posedge mclk) begin
        if (srst) begin
            test_status_ff <= TEST_STATUS_RST;
            play_ff        <= 1'b0;
            frame_ff       <= 4'h0;
        end else begin
            test_status_ff <= nxt_test_status;
            play_ff        <= nxt_play;
            frame_ff       <= nxt_frame;
        end
    end

    // ************************************************************
    // interrupt causes
    // ************************************************************
    logic started_ff, nxt_started;                    // first cycle after reset seen
    logic por_flag_ff, nxt_por_flag;                  // power-on cause pending
    logic bus_flag_ff, nxt_bus_flag;                  // timeout cause pending
    logic por_set;                                    // start-up event

    // sticky causes: a read clears them, a set in the same cycle wins
    always_comb begin
        nxt_started  = 1'b1;
        por_set      = !started_ff;
        nxt_por_flag = (por_flag_ff && !rd_dev) || por_set;
        nxt_bus_flag = (bus_flag_ff && !rd_dev) || bus_timeout;
    end

    // causes clear under reset; start-up marks itself once released
    always_ff @(posedge mclk) begin
        if (srst) begin
            started_ff  <= 1'b0;
            por_flag_ff <= 1'b0;
            bus_flag_ff <= 1'b0;
        end else begin
            started_ff  <= nxt_started;
            por_flag_ff <= nxt_por_flag;
            bus_flag_ff <= nxt_bus_flag;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] dev_status;                           // assembled status byte
    logic [7:0] rdata_ff, nxt_rdata;                  // read data

    // status byte; both causes together give the value both
    always_comb begin
        dev_status                    = DEV_STATUS_RST;
        dev_status[DEV_PLAY_BIT]      = play_ff;
        dev_status[DEV_INT_LSB +: 2]  = {bus_flag_ff, por_flag_ff};
        dev_status[DEV_FRAME_LSB +: 4] = frame_ff;
    end

    // read mux; unmapped addresses read zero, data holds between reads
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_WDG_CTRL:    nxt_rdata = wdg_ctrl_ff;
                ADDR_TEST_STATUS: nxt_rdata = test_status_ff;
                ADDR_DEV_STATUS:  nxt_rdata = dev_status;
                default:          nxt_rdata = 8'h00;
            endcase
        end
    end

    // read data register
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_dev_read;
        rd_dev ##1 1'b1;
    endsequence

    sequence s_quiet_read;
        rd_dev && !bus_timeout && started_ff;
    endsequence

    // a status read while the bus cause is pending
    sequence s_bus_cause_read;
        rd_dev && bus_flag_ff;
    endsequence

    // a status read while the power-on cause is pending
    sequence s_por_cause_read;
        rd_dev && por_flag_ff;
    endsequence

    // all ones on the first cycle after reset
    chk_wdg_reset_val: assert property (@(posedge mclk) disable iff (srst)
        $fell(srst) |-> wdg_ctrl_ff == 8'hff)
        else $error("monitoring register not all ones after reset");

    // a write lands on the next edge
    chk_wdg_write: assert property (@(posedge mclk) disable iff (srst)
        wr_wdg |=> wdg_ctrl_ff == $past(reg_wdata))
        else $error("monitoring register write lost");

    // test status reads the sample taken before the read
    chk_test_readback: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr == 8'h0c && !$fell(srst)
        |=> reg_rdata == {1'b0, $past(test_in.busy, 2), $past(test_in.shorted, 2),
                          $past(test_in.opened, 2)})
        else $error("test status read does not follow test state");

    // busy shows one cycle after its source
    chk_test_busy_bit: assert property (@(posedge mclk) disable iff (srst)
        $past(test_in.busy) && !$fell(srst) |-> test_status_ff[6])
        else $error("test busy bit missing");

    // a quiet status read leaves no cause pending
    chk_read_clear: assert property (@(posedge mclk) disable iff (srst)
        s_quiet_read |=> bus_flag_ff == 1'b0 && por_flag_ff == 1'b0)
        else $error("status read did not clear interrupt bits");

    // start-up sets the power-on cause
    chk_por_startup: assert property (@(posedge mclk) disable iff (srst)
        $fell(srst) |=> por_flag_ff ##1 (por_flag_ff || $past(rd_dev)))
        else $error("power-on cause not set after start-up");

    // the timer pulse sets the bus cause
    chk_timeout_flag: assert property (@(posedge mclk) disable iff (srst)
        bus_timeout |=> bus_flag_ff)
        else $error("timeout did not set the bus cause");

    // a status read returns every field as it stood
    chk_status_fields: assert property (@(posedge mclk) disable iff (srst)
        s_dev_read |-> reg_rdata[5:4] == {$past(bus_flag_ff), $past(por_flag_ff)}
                       && reg_rdata[6] == $past(play_ff)
                       && reg_rdata[3:0] == $past(frame_ff) && !reg_rdata[7])
        else $error("device status read fields wrong");

    // no interface reset while monitoring is off
    chk_monitor_off: assert property (@(posedge mclk) disable iff (srst)
        !wdg_ctrl_ff[0] ##1 !wdg_ctrl_ff[0] |-> !slave_reset)
        else $error("slave reset while monitoring off");

    // the interface reset lasts one cycle only
    chk_pulse_single: assert property (@(posedge mclk) disable iff (srst)
        slave_reset |=> !slave_reset)
        else $error("slave reset pulse longer than one cycle");

    // the monitoring register reads back what it holds
    chk_wdg_readback: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr == ADDR_WDG_CTRL |=> reg_rdata == $past(wdg_ctrl_ff))
        else $error("monitoring register read back wrong");

    // only a write to its own address changes the monitoring register
    chk_wdg_hold: assert property (@(posedge mclk) disable iff (srst)
        !wr_wdg |=> $stable(wdg_ctrl_ff))
        else $error("monitoring register changed without a write");

    // unmapped addresses read zero
    chk_unmapped_zero: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr != ADDR_WDG_CTRL && reg_addr != ADDR_TEST_STATUS
        && reg_addr != ADDR_DEV_STATUS |=> reg_rdata == 8'h00)
        else $error("unmapped address read not zero");

    // read data stands between reads
    chk_rdata_hold: assert property (@(posedge mclk) disable iff (srst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // playing flag and frame follow the animation state
    chk_anim_follow: assert property (@(posedge mclk) disable iff (srst)
        !$fell(srst) |-> play_ff == $past(anim_in.playing)
                         && frame_ff == $past(anim_in.frame))
        else $error("animation status does not follow its source");

    // a pending bus cause is reported by the read that clears it
    chk_bus_cause_read: assert property (@(posedge mclk) disable iff (srst)
        s_bus_cause_read |=> reg_rdata[5])
        else $error("pending bus cause not reported");

    // a pending power-on cause is reported by the read that clears it
    chk_por_cause_read: assert property (@(posedge mclk) disable iff (srst)
        s_por_cause_read |=> reg_rdata[4])
        else $error("pending power-on cause not reported");

endmodule : bus_watchdog_and_status_regs

`default_nettype wire

// ==== verification/bus_line_model.sv ====
// far-side model of the serial bus lines as the status block sees them
// assumes the bench picks the line pattern through mode, changed just after mclk edges
`timescale 1ns/1ns
`default_nettype none

module bus_line_model (
    input  wire logic       mclk,   // system clock
    input  wire logic [1:0] mode,   // 0 idle, 1 data stuck low, 2 traffic
    output logic            sda,    // data line level
    output logic            scl     // clock line level
);
    logic [1:0] div_ff = 2'h0;      // divides mclk for the traffic clock

    // ************************************************************
    // line levels
    // ************************************************************
    // free-running divider; scl only follows it in traffic mode
    always @(posedge mclk) begin
        div_ff <= div_ff + 2'h1;
    end

    // released lines sit at the pull-up level, so idle reads high
    assign sda = (mode == 2'h0);
    assign scl = (mode == 2'h2) ? div_ff[1] : 1'b1;
endmodule : bus_line_model

`default_nettype wire

// ==== verification/bus_watchdog_and_status_regs_test.sv ====
// self-checking bench for the watchdog and status register bank
// assumes a shortened window unit and the line model on the serial pins
`timescale 1ns/1ns
`default_nettype none

module bus_watchdog_and_status_regs_test;
    import wdg_status_pkg::*;
    localparam int UNIT = 4;        // shortened window unit in cycles

    logic        mclk;              // system clock
    logic        srst;              // sync reset
    logic        reg_wr;            // write strobe
    logic        reg_rd;            // read strobe
    logic [7:0]  reg_addr;          // register address
    logic [7:0]  reg_wdata;         // write data
    logic [7:0]  reg_rdata;         // read data
    logic        slave_reset;       // interface reset pulse
    wire         sda_in;            // data line from the model
    wire         scl_in;            // clock line from the model
    led_test_t   test_in;           // self-test state
    anim_state_t anim_in;           // animation state
    logic [1:0]  line_mode;         // line model pattern
    logic [7:0]  exp_q[$];          // expected read data, oldest first
    logic [7:0]  v;                 // random scratch
    int          mismatches = 0;    // failed comparisons
    int          n_tests    = 0;    // comparisons made
    int          pulses     = 0;    // interface reset pulses seen
    int          p0;                // pulse count snapshot

    bus_watchdog_and_status_regs #(.UNIT_CYCLES(UNIT)) u_bus_watchdog_and_status_regs (
        .mclk        (mclk),
        .srst        (srst),
        .reg_addr    (reg_addr),
        .reg_wr      (reg_wr),
        .reg_wdata   (reg_wdata),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .sda_in      (sda_in),
        .scl_in      (scl_in),
        .slave_reset (slave_reset),
        .test_in     (test_in),
        .anim_in     (anim_in)
    );

    bus_line_model u_bus_line_model (
        .mclk (mclk),
        .mode (line_mode),
        .sda  (sda_in),
        .scl  (scl_in)
    );

    // ************************************************************
    // clock, compare and report
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // one comparison, counted, reported at once on mismatch
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // prints the counts and the verdict, then ends the run
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // read data lands one cycle after the strobe; compare mid-cycle
    always @(posedge mclk) begin
        if (reg_rd === 1'b1) begin
            @(negedge mclk);
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, reg_rdata, 8'hxx);
            end else
                check(reg_rdata, exp_q.pop_front());
        end
    end

    // counts interface reset pulses, mid-cycle where the pulse is settled
    always @(negedge mclk) begin
        if (slave_reset === 1'b1)
            pulses++;
    end

    // hang guard
    initial begin
        #(100 * 60000);
        mismatches++;
        report_and_stop();
    end

    // ************************************************************
    // driver tasks
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        tick(1);
        reg_wr    = 1'b0;
    endtask : wr

    // read strobe; the expected value is queued for the watcher
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        tick(1);
        reg_addr = a;
        reg_rd   = 1'b1;
        exp_q.push_back(exp);
        tick(1);
        reg_rd   = 1'b0;
    endtask : rd

    // holds data low and checks the cycles to the next reset pulse
    task automatic stuck_pulse(input int win);
        int start;
        int cyc;
        start     = pulses;
        cyc       = 0;
        line_mode = 2'h1;
        while (pulses == start && cyc < win + 8) begin
            tick(1);
            cyc++;
        end
        line_mode = 2'h0;
        // one cycle to see the falling edge, one for the registered pulse
        check({7'h0, cyc == win + 2}, 8'h01);
    endtask : stuck_pulse

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h5f764bfc));
        srst      = 1'b1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        test_in   = '0;
        anim_in   = '0;
        line_mode = 2'h0;
        tick(16);
        srst = 1'b0;
        tick(3);
        rd(ADDR_WDG_CTRL, WDG_CTRL_RST);
        rd(ADDR_TEST_STATUS, TEST_STATUS_RST);
        rd(ADDR_DEV_STATUS, 8'h10);
        rd(ADDR_DEV_STATUS, DEV_STATUS_RST);
        // writes to read-only and unmapped places change nothing
        wr(ADDR_TEST_STATUS, 8'h5a);
        wr(ADDR_DEV_STATUS, 8'h7f);
        wr(8'h20, 8'ha5);
        rd(ADDR_TEST_STATUS, 8'h00);
        rd(ADDR_DEV_STATUS, 8'h00);
        rd(8'h20, 8'h00);
        // walking one over each result bit, then random results
        for (int i = 0; i < 10; i++) begin
            v       = 8'($urandom);
            test_in = (i < 7) ? (7'h01 << i) : v[6:0];
            tick(2);
            rd(ADDR_TEST_STATUS, {1'b0, test_in});
        end
        test_in = '0;
        // every frame index, playing flag random
        for (int f = 0; f < 6; f++) begin
            v       = 8'($urandom);
            anim_in = {v[0], 4'(f)};
            tick(2);
            rd(ADDR_DEV_STATUS, {1'b0, v[0], 2'h0, 4'(f)});
        end
        anim_in = '0;
        // random window with the monitor off: stuck line is left alone
        v = 8'($urandom);
        wr(ADDR_WDG_CTRL, {v[7:1], 1'b0});
        rd(ADDR_WDG_CTRL, {v[7:1], 1'b0});
        p0        = pulses;
        line_mode = 2'h1;
        tick(600);
        line_mode = 2'h0;
        check(8'(pulses - p0), 8'h00);
        // monitor on, short window, ongoing traffic never trips it
        wr(ADDR_WDG_CTRL, 8'h03);
        p0        = pulses;
        line_mode = 2'h2;
        tick(60);
        line_mode = 2'h0;
        check(8'(pulses - p0), 8'h00);
        // stuck data line trips after (n+1) units, cause reads 10
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : 8'h05;
            wr(ADDR_WDG_CTRL, {v[6:0], 1'b1});
            stuck_pulse((v + 1) * UNIT);
            tick(2);
            rd(ADDR_DEV_STATUS, 8'h20);
            rd(ADDR_DEV_STATUS, 8'h00);
        end
        // second start-up: default window, both causes pending
        srst = 1'b1;
        tick(16);
        srst = 1'b0;
        stuck_pulse(128 * UNIT);
        tick(2);
        rd(ADDR_DEV_STATUS, 8'h30);
        rd(ADDR_DEV_STATUS, 8'h00);
        tick(4);
        report_and_stop();
    end
endmodule : bus_watchdog_and_status_regs_test

`default_nettype wire
